// ===== src/input_function_pkg.sv
package input_function_pkg;

  // ---------------------------------------------------------------
  // function codes
  // ---------------------------------------------------------------
  localparam int CODE_W = 6;
  localparam logic [CODE_W-1:0] FN_OFF = 6'h00;
  localparam logic [CODE_W-1:0] FN_START = 6'h01;
  localparam logic [CODE_W-1:0] FN_NEGATE = 6'h02;
  localparam logic [CODE_W-1:0] FN_QSTOP_N = 6'h03;
  localparam logic [CODE_W-1:0] FN_OFFSET_ONE = 6'h04;
  localparam logic [CODE_W-1:0] FN_OFFSET_TWO = 6'h05;
  localparam logic [CODE_W-1:0] FN_TABLE_BIT0 = 6'h06;
  localparam logic [CODE_W-1:0] FN_PROG_BIT0 = 6'h0B;
  localparam logic [CODE_W-1:0] FN_LIMIT_POS_N = 6'h14;
  localparam logic [CODE_W-1:0] FN_LIMIT_NEG_N = 6'h15;
  localparam logic [CODE_W-1:0] FN_EXT_FAULT = 6'h16;
  localparam logic [CODE_W-1:0] FN_JOG_POS = 6'h17;
  localparam logic [CODE_W-1:0] FN_JOG_NEG = 6'h18;
  localparam logic [CODE_W-1:0] FN_TABLE_ACCEPT = 6'h1B;
  localparam logic [CODE_W-1:0] FN_TRIGGER = 6'h1C;
  localparam logic [CODE_W-1:0] FN_AUTO = 6'h1D;
  localparam logic [CODE_W-1:0] FN_FEED_HOLD = 6'h1E;
  localparam logic [CODE_W-1:0] FN_UPDATE_HOLD = 6'h1F;
  localparam logic [CODE_W-1:0] FN_FAULT_CLEAR = 6'h23;
  localparam logic [CODE_W-1:0] FN_ZERO_MASK_N = 6'h27;
  localparam logic [CODE_W-1:0] FN_POS_HOLD = 6'h28;
  localparam logic [CODE_W-1:0] FN_PROBE_A = 6'h2B;
  localparam logic [CODE_W-1:0] FN_PROBE_B = 6'h2C;
  localparam int TABLE_BITS = 5;
  localparam int PROG_BITS = 8;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FUNC_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_PROBE_A = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_PROBE_B = 8'h4C;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_REF = 8'h50;

  // ctrl fields
  localparam int CTRL_AUTOSTART = 0;
  localparam int CTRL_CODING_LO = 1;
  localparam int CTRL_FIXED_POS = 3;
  localparam int CTRL_SPEED_CTL = 4;
  localparam int CTRL_COND_STD = 5;
  localparam int CTRL_ARM_A = 6;
  localparam int CTRL_ARM_B = 7;
  localparam int CTRL_PROG_LO = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  localparam logic [1:0] CODING_PARAM = 2'h3;

  // status fields; probe flags are write-one-to-clear
  localparam int ST_PROBE_A = 8;
  localparam int ST_PROBE_B = 9;
  localparam int ST_EXP_LO = 16;

  // fast probe inputs among the standard terminals
  localparam int FAST_THREE = 3;
  localparam int FAST_FOUR = 4;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_PROGRAM = 2'b01,
    RUN_HOMING = 2'b11
  } run_state_t;

endpackage

// ===== src/input_sync.sv
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // first stage feeds only the second
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_reg <= '0;
      q <= '0;
    end else begin
      stage_reg <= d;
      q <= stage_reg;
    end
  end

endmodule

`default_nettype wire

// ===== src/drive_input_function_logic.sv
`timescale 1ns/1ps
`default_nettype none

module drive_input_function_logic
  import input_function_pkg::*;
#(
  parameter int NUM_STD = 5,
  parameter int NUM_EXP = 8,
  parameter int POS_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_STD-1:0] stdInputs,
  input wire logic [NUM_EXP-1:0] expansionInputs,
  input wire logic expansionPresent,
  input wire logic powerStageEnable,
  input wire logic [POS_W-1:0] actualPosition,
  input wire logic axleMoving,
  input wire logic homingDone,
  input wire logic programDone,
  output logic loopEnable,
  output logic referenceNegate,
  output logic quickStopBrake,
  output logic selectorOffsetOne,
  output logic selectorOffsetTwo,
  output logic [TABLE_BITS-1:0] tableIndex,
  output logic tableSetStart,
  output logic [PROG_BITS-1:0] programIndex,
  output logic programStart,
  output logic programRunning,
  output logic programPaused,
  output logic autoMode,
  output logic homingRun,
  output logic homingReverse,
  output logic motionStop,
  output logic externalFault,
  output logic jogPositive,
  output logic jogNegative,
  output logic jogFast,
  output logic motionPermit,
  output logic feedAbort,
  output logic feedResume,
  output logic simZeroPulseMask,
  output logic positionHoldEnable,
  output logic [POS_W-1:0] holdReference
);

  localparam int NI = NUM_STD + NUM_EXP;
  localparam int NF = 2 ** CODE_W;

  if (NUM_STD <= FAST_FOUR || NUM_EXP < 1 || NI > 16 || POS_W < 1 || POS_W > 32) begin : paramCheck
    $error("unsupported parameters");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic activeLow(input logic [CODE_W-1:0] code);
    return code == FN_QSTOP_N || code == FN_LIMIT_POS_N || code == FN_LIMIT_NEG_N || code == FN_ZERO_MASK_N;
  endfunction

  function automatic logic [31:0] funcAddr(input int idx);
    return 32'(ADDR_FUNC_BASE) + 32'(idx * 4);
  endfunction

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  logic [NUM_STD-1:0] stdSync;
  logic [NUM_EXP-1:0] expSync;
  logic [NI-1:0] level;

  input_sync #(.WIDTH(NUM_STD)) stdSyncInst (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(stdInputs),
    .q(stdSync)
  );

  input_sync #(.WIDTH(NUM_EXP)) expSyncInst (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(expansionInputs),
    .q(expSync)
  );

  assign level = {expSync & {NUM_EXP{expansionPresent}}, stdSync};

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] funcCode_reg [NI];
  logic [31:0] ctrl_reg;
  logic probeValidA_reg;
  logic probeValidB_reg;
  logic [POS_W-1:0] probeA_reg;
  logic [POS_W-1:0] probeB_reg;
  logic [31:0] status;

  wire logic wrEn = psel && penable && pwrite;
  wire logic setupPhase = psel && !penable;
  assign pready = 1'b1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NI; i++) begin
        funcCode_reg[i] <= FN_OFF;
      end
      ctrl_reg <= CTRL_RESET;
    end else if (wrEn) begin
      for (int i = 0; i < NI; i++) begin
        if (32'(paddr) == funcAddr(i)) begin
          funcCode_reg[i] <= pwdata[CODE_W-1:0];
        end
      end
      if (paddr == ADDR_CTRL) begin
        ctrl_reg <= pwdata;
      end
    end
  end

  logic [31:0] readMux;
  logic mapped;
  always_comb begin
    readMux = '0;
    mapped = 1'b1;
    unique case (paddr)
      ADDR_CTRL: readMux = ctrl_reg;
      ADDR_STATUS: readMux = status;
      ADDR_PROBE_A: readMux = 32'(probeA_reg);
      ADDR_PROBE_B: readMux = 32'(probeB_reg);
      ADDR_HOLD_REF: readMux = 32'(holdReference);
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < NI; i++) begin
          if (32'(paddr) == funcAddr(i)) begin
            readMux = 32'(funcCode_reg[i]);
            mapped = 1'b1;
          end
        end
      end
    endcase
  end

  // read data taken in setup so the access completes at once
  logic mapped_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
      mapped_reg <= 1'b0;
    end else if (setupPhase) begin
      prdata <= readMux;
      mapped_reg <= mapped;
    end
  end
  assign pslverr = psel && penable && !mapped_reg;

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  logic [NF-1:0] act;
  always_comb begin
    act = '0;
    for (int i = 0; i < NI; i++) begin
      if (funcCode_reg[i] != FN_OFF) begin
        act[funcCode_reg[i]] |= level[i] ^ activeLow(funcCode_reg[i]);
      end
    end
  end

  logic [NF-1:0] asg;
  always_comb begin
    asg = '0;
    for (int i = 0; i < NI; i++) begin
      asg[funcCode_reg[i]] = 1'b1;
    end
  end

  // edges wait one cycle after reset so a held level is no edge
  logic primed_reg;
  logic [NF-1:0] prevAct_reg;
  logic [NF-1:0] rise;
  logic [NF-1:0] fall;
  logic permit;
  logic permitPrev_reg;
  logic updateOk;
  logic updatePrev_reg;
  logic [NUM_STD-1:0] prevStd_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      primed_reg <= 1'b0;
      prevAct_reg <= '0;
      permitPrev_reg <= 1'b1;
      updatePrev_reg <= 1'b1;
      prevStd_reg <= '0;
    end else begin
      primed_reg <= 1'b1;
      prevAct_reg <= act;
      permitPrev_reg <= permit;
      updatePrev_reg <= updateOk;
      prevStd_reg <= stdSync;
    end
  end

  assign rise = act & ~prevAct_reg & {NF{primed_reg}};
  assign fall = ~act & prevAct_reg & {NF{primed_reg}};
  assign permit = !asg[FN_FEED_HOLD] || act[FN_FEED_HOLD];
  assign updateOk = !asg[FN_UPDATE_HOLD] || act[FN_UPDATE_HOLD];

  wire logic autostart = ctrl_reg[CTRL_AUTOSTART];
  wire logic [1:0] coding = ctrl_reg[CTRL_CODING_LO +: 2];
  wire logic fixedPos = ctrl_reg[CTRL_FIXED_POS];
  wire logic speedCtl = ctrl_reg[CTRL_SPEED_CTL];
  wire logic condStd = ctrl_reg[CTRL_COND_STD];

  // ---------------------------------------------------------------
  // loop enable, quick stop, fault
  // ---------------------------------------------------------------
  logic startLvl;
  assign startLvl = act[FN_START];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loopEnable <= 1'b0;
    end else if (!powerStageEnable || !startLvl) begin
      loopEnable <= 1'b0;
    end else if (rise[FN_START] || (autostart && primed_reg)) begin
      loopEnable <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quickStopBrake <= 1'b0;
    end else if (act[FN_QSTOP_N]) begin
      quickStopBrake <= 1'b1;
    end else if (!startLvl) begin
      quickStopBrake <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      externalFault <= 1'b0;
    end else if (act[FN_EXT_FAULT]) begin
      externalFault <= 1'b1;
    end else if (act[FN_FAULT_CLEAR]) begin
      externalFault <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // reference path
  // ---------------------------------------------------------------
  logic [TABLE_BITS-1:0] tableLive;
  logic [TABLE_BITS-1:0] tableLatched_reg;
  logic [PROG_BITS-1:0] progLive;
  assign tableLive = act[FN_TABLE_BIT0 +: TABLE_BITS];
  assign progLive = (coding == CODING_PARAM) ? ctrl_reg[CTRL_PROG_LO +: PROG_BITS]
                                             : act[FN_PROG_BIT0 +: PROG_BITS];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      referenceNegate <= 1'b0;
      selectorOffsetOne <= 1'b0;
      selectorOffsetTwo <= 1'b0;
      simZeroPulseMask <= 1'b0;
      tableLatched_reg <= '0;
      tableSetStart <= 1'b0;
    end else begin
      referenceNegate <= act[FN_NEGATE];
      selectorOffsetOne <= act[FN_OFFSET_ONE];
      selectorOffsetTwo <= act[FN_OFFSET_TWO];
      simZeroPulseMask <= act[FN_ZERO_MASK_N];
      tableSetStart <= rise[FN_TABLE_ACCEPT] && fixedPos;
      if (rise[FN_TABLE_ACCEPT] && fixedPos) begin
        tableLatched_reg <= tableLive;
      end
    end
  end
  assign tableIndex = fixedPos ? tableLatched_reg : tableLive;

  // ---------------------------------------------------------------
  // mode and program sequencing
  // ---------------------------------------------------------------
  run_state_t runState_reg;
  logic stopAll;
  logic autoAbort;
  assign stopAll = externalFault || quickStopBrake || !loopEnable;
  assign autoAbort = fall[FN_AUTO];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      autoMode <= 1'b0;
    end else if (!act[FN_AUTO]) begin
      autoMode <= 1'b0;
    end else if (rise[FN_AUTO]) begin
      autoMode <= 1'b1;
    end
  end

  // an aborted program is dropped, so only a new trigger restarts it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      runState_reg <= RUN_IDLE;
      programStart <= 1'b0;
      programIndex <= '0;
    end else begin
      programStart <= 1'b0;
      unique case (runState_reg)
        RUN_IDLE: begin
          if (rise[FN_TRIGGER] && !stopAll) begin
            if (autoMode && condStd) begin
              runState_reg <= RUN_PROGRAM;
              programStart <= 1'b1;
              programIndex <= progLive;
            end else if (!autoMode && !act[FN_AUTO]) begin
              runState_reg <= RUN_HOMING;
            end
          end
        end
        RUN_PROGRAM: begin
          if (autoAbort || programDone || stopAll) begin
            runState_reg <= RUN_IDLE;
          end
        end
        RUN_HOMING: begin
          if (homingDone || stopAll || rise[FN_AUTO]) begin
            runState_reg <= RUN_IDLE;
          end
        end
        default: runState_reg <= RUN_IDLE;
      endcase
    end
  end
  assign programRunning = runState_reg == RUN_PROGRAM;
  assign homingRun = runState_reg == RUN_HOMING;

  // ---------------------------------------------------------------
  // motion gating
  // ---------------------------------------------------------------
  logic jogDirNeg_reg;
  wire logic limitPos = act[FN_LIMIT_POS_N];
  wire logic limitNeg = act[FN_LIMIT_NEG_N];
  wire logic limitTrip = rise[FN_LIMIT_POS_N] || rise[FN_LIMIT_NEG_N];
  wire logic jogPosOnly = act[FN_JOG_POS] && !act[FN_JOG_NEG];
  wire logic jogNegOnly = act[FN_JOG_NEG] && !act[FN_JOG_POS];
  wire logic jogBoth = act[FN_JOG_POS] && act[FN_JOG_NEG];
  wire logic manual = !autoMode && !homingRun;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      jogDirNeg_reg <= 1'b0;
    end else if (jogPosOnly || jogNegOnly) begin
      jogDirNeg_reg <= jogNegOnly;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      jogPositive <= 1'b0;
      jogNegative <= 1'b0;
      jogFast <= 1'b0;
      motionStop <= 1'b0;
      homingReverse <= 1'b0;
      motionPermit <= 1'b1;
      feedAbort <= 1'b0;
      feedResume <= 1'b0;
      programPaused <= 1'b0;
    end else begin
      jogPositive <= manual && permit && !limitPos
        && (jogPosOnly || (jogBoth && !jogDirNeg_reg));
      jogNegative <= manual && permit && !limitNeg
        && (jogNegOnly || (jogBoth && jogDirNeg_reg));
      jogFast <= manual && jogBoth;
      motionStop <= (limitTrip && !homingRun) || rise[FN_EXT_FAULT]
        || (autoAbort && axleMoving);
      homingReverse <= limitTrip && homingRun;
      motionPermit <= permit;
      feedAbort <= !permit && permitPrev_reg && primed_reg;
      feedResume <= permit && !permitPrev_reg && primed_reg;
      programPaused <= !updateOk && programRunning;
    end
  end

  // ---------------------------------------------------------------
  // position hold and probes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      positionHoldEnable <= 1'b0;
      holdReference <= '0;
    end else begin
      positionHoldEnable <= act[FN_POS_HOLD] && speedCtl;
      if (rise[FN_POS_HOLD] && speedCtl) begin
        holdReference <= actualPosition;
      end
    end
  end

  wire logic armA = ctrl_reg[CTRL_ARM_A] && asg[FN_PROBE_A] && !probeValidA_reg;
  wire logic armB = ctrl_reg[CTRL_ARM_B] && asg[FN_PROBE_B] && !probeValidB_reg;
  wire logic edgeA = stdSync[FAST_THREE] && !prevStd_reg[FAST_THREE] && primed_reg;
  wire logic edgeB = stdSync[FAST_FOUR] && !prevStd_reg[FAST_FOUR] && primed_reg;
  wire logic clrA = wrEn && paddr == ADDR_STATUS && pwdata[ST_PROBE_A];
  wire logic clrB = wrEn && paddr == ADDR_STATUS && pwdata[ST_PROBE_B];

  // a capture in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      probeValidA_reg <= 1'b0;
      probeValidB_reg <= 1'b0;
      probeA_reg <= '0;
      probeB_reg <= '0;
    end else begin
      if (armA && edgeA) begin
        probeA_reg <= actualPosition;
        probeValidA_reg <= 1'b1;
      end else if (clrA) begin
        probeValidA_reg <= 1'b0;
      end
      if (armB && edgeB) begin
        probeB_reg <= actualPosition;
        probeValidB_reg <= 1'b1;
      end else if (clrB) begin
        probeValidB_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    status = '0;
    status[0] = loopEnable;
    status[1] = autoMode;
    status[2] = programRunning;
    status[3] = homingRun;
    status[4] = externalFault;
    status[5] = limitPos;
    status[6] = limitNeg;
    status[7] = quickStopBrake;
    status[ST_PROBE_A] = probeValidA_reg;
    status[ST_PROBE_B] = probeValidB_reg;
    status[10] = motionPermit;
    status[11] = programPaused;
    status[ST_EXP_LO +: NUM_EXP] = level[NI-1:NUM_STD];
  end

endmodule

`default_nettype wire

// ===== dv/drive_input_function_logic_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_logic_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic powerStageEnable,
  input wire logic loopEnable,
  input wire logic programStart,
  input wire logic programRunning,
  input wire logic homingRun,
  input wire logic homingReverse,
  input wire logic autoMode,
  input wire logic jogPositive,
  input wire logic jogNegative,
  input wire logic jogFast,
  input wire logic feedAbort,
  input wire logic feedResume,
  input wire logic motionPermit,
  input wire logic tableSetStart
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_loop_power: assert property (!powerStageEnable [*5] |-> !loopEnable)
    else $error("loop without power");
  a_start_runs: assert property (programStart |-> programRunning)
    else $error("start not running");
  a_run_excl: assert property (!(homingRun && programRunning))
    else $error("homing with program");
  a_jog_excl: assert property (!(jogPositive && jogNegative))
    else $error("jog both ways");
  a_jog_fast: assert property (jogFast |-> jogPositive || jogNegative)
    else $error("fast jog idle");
  a_auto_fall: assert property ($fell(autoMode) |-> ##[0:2] !programRunning)
    else $error("run after auto fall");
  a_feed_abort: assert property (feedAbort |-> ##[0:1] !motionPermit)
    else $error("abort with permit");
  a_feed_resume: assert property (feedResume |-> ##[0:1] motionPermit)
    else $error("resume no permit");
  a_table_pulse: assert property (tableSetStart |=> !tableSetStart)
    else $error("table start held");
  a_home_rev: assert property (homingReverse |-> homingRun || $past(homingRun))
    else $error("reverse outside homing");
endmodule
bind drive_input_function_logic drive_input_function_logic_monitor i_mon (.sys_clk, .rst, .psel, .penable,
  .pslverr, .powerStageEnable, .loopEnable, .programStart, .programRunning, .homingRun, .homingReverse,
  .autoMode, .jogPositive, .jogNegative, .jogFast, .feedAbort, .feedResume, .motionPermit, .tableSetStart);
`default_nettype wire

// ===== dv/terminal_model.sv
`timescale 1ns/1ps
`default_nettype none
module terminal_model (
  input wire logic sys_clk,
  input wire logic [4:0] stdLevel,
  input wire logic [7:0] expLevel,
  input wire logic homingRun,
  output logic [4:0] stdInputs,
  output logic [7:0] expansionInputs,
  output logic axleMoving,
  output logic homingDone
);
  int homeCnt = 0;
  initial begin
    stdInputs = 5'h00;
    expansionInputs = 8'h00;
    axleMoving = 1'b0;
    homingDone = 1'b0;
  end
  // contacts settle one clock late; homing ends after a fixed travel
  always @(posedge sys_clk) begin
    stdInputs <= stdLevel;
    expansionInputs <= expLevel;
    axleMoving <= homingRun;
    homeCnt <= homingRun ? homeCnt + 1 : 0;
    homingDone <= (homeCnt == 200);
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import input_function_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int LAT = 6;
  typedef struct {logic [5:0] c; logic lvl; logic [3:0] exp;} row_t;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, expansionPresent = 1;
  logic powerStageEnable = 0, programDone = 0, pready, pslverr, axleMoving, homingDone, rdErr;
  logic [7:0] paddr = 8'h00, expLvl = 8'h00, expansionInputs, programIndex;
  logic [4:0] stdLvl = 5'h00, stdInputs, tableIndex;
  logic [31:0] pwdata = 32'h0, actualPosition = 32'h0, prdata, holdReference, rdData;
  logic loopEnable, referenceNegate, quickStopBrake, selectorOffsetOne, selectorOffsetTwo, tableSetStart;
  logic programStart, programRunning, programPaused, autoMode, homingRun, homingReverse, motionStop;
  logic externalFault, jogPositive, jogNegative, jogFast, motionPermit, feedAbort, feedResume;
  logic simZeroPulseMask, positionHoldEnable;
  int n_errors, n_checks, cyc, nTab, nProg, nRev, nStop, nAbort, nRes;
  row_t rows[5] = '{'{FN_OFF, 1'b1, 4'h0},
    '{FN_NEGATE, 1'b1, 4'h8}, '{FN_OFFSET_ONE, 1'b1, 4'h4},
    '{FN_OFFSET_TWO, 1'b1, 4'h2}, '{FN_ZERO_MASK_N, 1'b0, 4'h1}};
  drive_input_function_logic i_drive_input_function_logic (.sys_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stdInputs, .expansionInputs, .expansionPresent,
    .powerStageEnable, .actualPosition, .axleMoving, .homingDone, .programDone, .loopEnable,
    .referenceNegate, .quickStopBrake, .selectorOffsetOne, .selectorOffsetTwo, .tableIndex, .tableSetStart,
    .programIndex, .programStart, .programRunning, .programPaused, .autoMode, .homingRun, .homingReverse,
    .motionStop, .externalFault, .jogPositive, .jogNegative, .jogFast, .motionPermit, .feedAbort,
    .feedResume, .simZeroPulseMask, .positionHoldEnable, .holdReference);
  terminal_model i_terminal_model (.sys_clk, .stdLevel(stdLvl), .expLevel(expLvl), .homingRun,
    .stdInputs, .expansionInputs, .axleMoving, .homingDone);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    nTab += tableSetStart;
    nProg += programStart;
    nRev += homingReverse;
    nStop += motionStop;
    nAbort += feedAbort;
    nRes += feedResume;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task code(input int i, input logic [5:0] c);
    apb(1'b1, ADDR_FUNC_BASE + 8'(4 * i), {26'h0, c});
  endtask
  task trig();
    @(posedge sys_clk) stdLvl[2] <= 1'b1;
    wt(10);
    @(posedge sys_clk) stdLvl[2] <= 1'b0;
    wt(LAT);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    wt(8);
    @(posedge sys_clk) rst <= 1'b0;
    wt(2);
    chk(motionPermit, 1, "permit");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdData, CTRL_RESET, "ctrl");
    apb(1'b0, 8'hFC, 32'h0);
    chk(rdErr, 1, "unmapped");
    foreach (rows[k]) begin
      code(5, rows[k].c);
      @(posedge sys_clk) expLvl[0] <= rows[k].lvl;
      wt(LAT);
      chk({referenceNegate, selectorOffsetOne, selectorOffsetTwo, simZeroPulseMask}, rows[k].exp, "row");
      code(5, FN_OFF);
    end
    for (int k = 0; k < 5; k++) code(6 + k, FN_TABLE_BIT0 + 6'(k));
    code(11, FN_PROG_BIT0);
    code(12, FN_TABLE_ACCEPT);
    @(posedge sys_clk) expLvl <= 8'hEC;
    wt(LAT);
    chk(tableIndex, 5'h16, "table");
    chk(nTab, 0, "accept ignored");
    apb(1'b1, ADDR_CTRL, CTRL_RESET | 32'h8);
    @(posedge sys_clk) expLvl[7] <= 1'b0;
    wt(LAT);
    @(posedge sys_clk) expLvl[7] <= 1'b1;
    wt(LAT);
    @(posedge sys_clk) expLvl[5:1] <= 5'h09;
    wt(LAT);
    chk(nTab, 1, "accept");
    chk(tableIndex, 5'h16, "latched");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdData[23:16], 8'hD2, "exp levels");
    @(posedge sys_clk) expansionPresent <= 1'b0;
    wt(LAT);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdData[23:16], 8'h00, "exp absent");
    @(posedge sys_clk) expansionPresent <= 1'b1;
    code(0, FN_START);
    @(posedge sys_clk) stdLvl[0] <= 1'b1;
    wt(LAT);
    chk(loopEnable, 0, "no power");
    @(posedge sys_clk) powerStageEnable <= 1'b1;
    apb(1'b1, ADDR_CTRL, CTRL_RESET | 32'h1);
    wt(LAT);
    chk(loopEnable, 1, "autostart");
    code(1, FN_AUTO);
    code(2, FN_TRIGGER);
    @(posedge sys_clk) stdLvl[1] <= 1'b1;
    wt(LAT);
    chk(autoMode, 1, "auto");
    trig();
    chk(nProg, 1, "start count");
    chk({programRunning, programIndex}, 9'h101, "program");
    code(4, FN_UPDATE_HOLD);
    wt(2);
    chk(programPaused, 1, "paused");
    @(posedge sys_clk) stdLvl[1] <= 1'b0;
    wt(LAT);
    chk({autoMode, programRunning}, 0, "abort");
    trig();
    chk(homingRun, 1, "homing");
    @(posedge sys_clk) expLvl[0] <= 1'b1;
    code(5, FN_LIMIT_POS_N);
    @(posedge sys_clk) expLvl[0] <= 1'b0;
    wt(LAT);
    chk({nRev, nStop}, 64'h1_0000_0000, "reverse");
    wt(200);
    @(posedge sys_clk) expLvl[0] <= 1'b1;
    wt(LAT);
    @(posedge sys_clk) expLvl[0] <= 1'b0;
    code(3, FN_JOG_POS);
    code(4, FN_JOG_NEG);
    @(posedge sys_clk) stdLvl[4:3] <= 2'b01;
    wt(LAT);
    chk({nStop, 31'h0, jogPositive}, 64'h1_0000_0000, "trip");
    @(posedge sys_clk) stdLvl[4:3] <= 2'b10;
    wt(LAT);
    chk(jogNegative, 1, "jog away");
    @(posedge sys_clk) stdLvl[4:3] <= 2'b01;
    expLvl[0] <= 1'b1;
    wt(LAT);
    @(posedge sys_clk) stdLvl[4] <= 1'b1;
    wt(LAT);
    chk({jogPositive, jogNegative, jogFast}, 3'h5, "fast jog");
    @(posedge sys_clk) stdLvl[4:3] <= 2'b00;
    code(5, FN_FEED_HOLD);
    @(posedge sys_clk) expLvl[0] <= 1'b0;
    wt(LAT);
    chk({motionPermit, nAbort}, 1, "feed abort");
    @(posedge sys_clk) expLvl[0] <= 1'b1;
    wt(LAT);
    chk({motionPermit, nRes}, 33'h1_0000_0001, "feed resume");
    code(5, FN_EXT_FAULT);
    code(4, FN_FAULT_CLEAR);
    @(posedge sys_clk) stdLvl[4] <= 1'b1;
    wt(LAT);
    chk(externalFault, 1, "fault kept");
    @(posedge sys_clk) expLvl[0] <= 1'b0;
    wt(LAT);
    chk(externalFault, 0, "fault cleared");
    code(5, FN_QSTOP_N);
    @(posedge sys_clk) expLvl[0] <= 1'b1;
    wt(LAT);
    chk(quickStopBrake, 1, "qstop held");
    @(posedge sys_clk) stdLvl[0] <= 1'b0;
    wt(LAT);
    chk(quickStopBrake, 0, "qstop clear");
    code(3, FN_PROBE_A);
    code(4, FN_POS_HOLD);
    apb(1'b1, ADDR_CTRL, CTRL_RESET | 32'h50);
    @(posedge sys_clk) stdLvl[4:3] <= 2'b00;
    actualPosition <= 32'h1234_5678;
    wt(LAT);
    @(posedge sys_clk) stdLvl[4:3] <= 2'b11;
    wt(LAT);
    @(posedge sys_clk) actualPosition <= 32'h0000_ABCD;
    apb(1'b0, ADDR_PROBE_A, 32'h0);
    chk(rdData, 32'h1234_5678, "probe");
    chk({positionHoldEnable, holdReference}, 33'h1_1234_5678, "hold");
    @(posedge sys_clk) powerStageEnable <= 1'b0;
    wt(LAT);
    end_of_test();
  end
endmodule
`default_nettype wire
